/* File: rtl/csc_pkg.sv */
`default_nettype none
package csc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register addresses in the special function register space.
  localparam logic [7:0] ADDR_CLOCK_SPEED = 8'h8f;
  localparam logic [7:0] ADDR_SYNTH_CTRL  = 8'he9;
  localparam logic [7:0] ADDR_REF_DIV     = 8'hee;
  localparam logic [7:0] ADDR_FB_DIV      = 8'hef;
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'he2;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'he3;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values.
  localparam int CKS_DOUBLE   = 0;
  localparam int CKS_TIMER0   = 1;
  localparam int CKS_TIMER1   = 2;
  localparam int CKS_UART     = 4;
  localparam int CKS_WATCHDOG = 6;
  localparam int CKS_TWOWIRE  = 7;
  localparam int SC_LOCK      = 0;
  localparam int SC_ENABLE    = 1;
  localparam int SC_RESET     = 3;
  localparam int SC_FB_LO     = 6;
  localparam int IRQ_LOCK_GAINED = 0;
  localparam int IRQ_LOCK_LOST   = 1;
  localparam int IRQ_W           = 2;
  localparam int SEL_W           = 5;

  localparam logic [7:0] SYNTH_CTRL_RESET = 8'h08;
  localparam logic [6:0] REF_DIV_RESET    = 7'h00;
  localparam logic [7:0] FB_DIV_RESET     = 8'h00;
  localparam logic [4:0] SEL_RESET        = 5'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Cycle counts and synthesiser loop constants.
  localparam logic [3:0]  MCYC_STD      = 4'hc;
  localparam logic [3:0]  MCYC_DOUBLE   = 4'h6;
  localparam logic [15:0] NCO_INIT      = 16'h4000;
  localparam logic [7:0]  LOCK_WINDOW   = 8'h04;
  localparam logic [3:0]  LOCK_REFS     = 4'h8;

  ////////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef struct packed {
    logic up;
    logic down;
    logic locked;
  } csc_pfd_t;

  typedef enum logic [1:0] {
    PFD_HOLD,
    PFD_WAIT_FB,
    PFD_FB_SEEN
  } csc_pfd_state_t;

endpackage
`default_nettype wire

/* File: rtl/csc_rate_gen.sv */
`default_nettype none
module csc_rate_gen
  import csc_pkg::*;
(
  // Clock and reset.
  input  wire logic core_clk_in,
  input  wire logic reset_in,
  // Speed control.
  input  wire logic boot_speed_in,
  input  wire logic double_speed_in,
  // Rate enables.
  output logic      div2_en_out,
  output logic      per_en_out,
  output logic      mcyc_en_out,
  output logic      double_active_out
);

  logic [3:0] osc_cnt;
  logic       div2_phase;
  logic       double_active;
  logic [3:0] mcyc_last;
  logic [4:0] gap_cnt;

  assign mcyc_last   = double_active ? (MCYC_DOUBLE - 4'h1) : (MCYC_STD - 4'h1);
  assign mcyc_en_out = (osc_cnt == mcyc_last);
  assign div2_en_out = div2_phase;
  assign per_en_out  = double_active | osc_cnt[0];
  assign double_active_out = double_active;

  // The speed only changes at the end of a machine cycle, so no enable pulse is cut short.
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      osc_cnt       <= 4'h0;
      div2_phase    <= 1'b0;
      double_active <= boot_speed_in;
    end
    else
    begin
      div2_phase <= ~div2_phase;
      osc_cnt    <= mcyc_en_out ? 4'h0 : osc_cnt + 4'h1;
      if (mcyc_en_out)
        double_active <= double_speed_in;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (reset_in || mcyc_en_out)
      gap_cnt <= 5'h01;
    else
      gap_cnt <= gap_cnt + 5'h01;
  end

  mcyc_length_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    mcyc_en_out && $past(mcyc_en_out, 12) && $stable(double_active) |->
      gap_cnt == (double_active ? 5'h06 : 5'h0c))
    else $error("Machine cycle length wrong.");

  switch_edge_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !$stable(double_active) |-> $past(mcyc_en_out))
    else $error("Speed changed inside a machine cycle.");

endmodule
`default_nettype wire

/* File: rtl/csc_phase_detect.sv */
`default_nettype none
module csc_phase_detect
  import csc_pkg::*;
(
  // Clock and reset.
  input  wire logic core_clk_in,
  input  wire logic reset_in,
  // Loop inputs.
  input  wire logic run_in,
  input  wire logic ref_tick_in,
  input  wire logic fb_tick_in,
  // Loop outputs.
  output csc_pfd_t  pfd_out
);

  csc_pfd_state_t state;
  csc_pfd_state_t next_state;
  logic [7:0]     gap;
  logic [3:0]     good_refs;
  logic           in_window;
  logic           pump_up;
  logic           pump_down;
  logic           lock_flag;

  assign in_window = (state == PFD_FB_SEEN) && (gap <= LOCK_WINDOW);
  assign pfd_out   = '{up: pump_up, down: pump_down, locked: lock_flag};

  // A missing feedback edge means the loop is slow; an early or doubled one means fast.
  always_comb
  begin
    next_state   = state;
    pump_up      = 1'b0;
    pump_down    = 1'b0;
    case (state)
      PFD_HOLD:
        if (ref_tick_in)
          next_state = PFD_WAIT_FB;
      PFD_WAIT_FB:
      begin
        if (fb_tick_in)
          next_state = PFD_FB_SEEN;
        else if (ref_tick_in)
          pump_up = 1'b1;
      end
      PFD_FB_SEEN:
      begin
        if (ref_tick_in)
        begin
          next_state   = fb_tick_in ? PFD_FB_SEEN : PFD_WAIT_FB;
          pump_down    = !in_window;
        end
        else if (fb_tick_in)
          pump_down = 1'b1;
      end
      default:
        next_state = PFD_HOLD;
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (reset_in || !run_in)
    begin
      state          <= PFD_HOLD;
      gap            <= 8'h00;
      good_refs      <= 4'h0;
      lock_flag      <= 1'b0;
    end
    else
    begin
      state <= next_state;
      gap   <= fb_tick_in ? 8'h00 : ((gap == 8'hff) ? gap : gap + 8'h01);
      if (ref_tick_in)
      begin
        good_refs      <= in_window ? ((good_refs == LOCK_REFS) ? good_refs : good_refs + 4'h1)
                                    : 4'h0;
        lock_flag      <= in_window && (good_refs >= LOCK_REFS - 4'h1);
      end
    end
  end

endmodule
`default_nettype wire

/* File: rtl/csc_clock_ctrl.sv */
`default_nettype none
module csc_clock_ctrl
  import csc_pkg::*;
(
  // Clock and reset.
  input  wire logic       core_clk_in,
  input  wire logic       reset_in,
  // Security byte fuse.
  input  wire logic       boot_speed_fuse_in,
  // Register port.
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic [7:0]      reg_rdata_out,
  // Core clock enables.
  output logic            osc_div2_en_out,
  output logic            cpu_clk_en_out,
  output logic            per_clk_en_out,
  output logic            mcyc_en_out,
  output logic            double_active_out,
  // Peripheral clock enables.
  output logic            twowire_clk_en_out,
  output logic            watchdog_clk_en_out,
  output logic            uart_clk_en_out,
  output logic            timer1_clk_en_out,
  output logic            timer0_clk_en_out,
  // Synthesiser clock enables.
  output logic            synth_clk_en_out,
  output logic            audio_clk_en_out,
  output logic            usb_clk_en_out,
  // Interrupt.
  output logic            irq_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic             double_speed_select;
  logic [SEL_W-1:0] periph_select;
  logic             synth_enable_bit;
  logic             synth_reset_bit;
  logic [6:0]       reference_divide_value;
  logic [7:0]       feedback_divide_upper;
  logic [1:0]       feedback_divide_lower;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic             lock_prev;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode.
  wire wr_speed  = reg_wr_in && (reg_addr_in == ADDR_CLOCK_SPEED);
  wire wr_ctrl   = reg_wr_in && (reg_addr_in == ADDR_SYNTH_CTRL);
  wire wr_ref    = reg_wr_in && (reg_addr_in == ADDR_REF_DIV);
  wire wr_fb     = reg_wr_in && (reg_addr_in == ADDR_FB_DIV);
  wire wr_status = reg_wr_in && (reg_addr_in == ADDR_IRQ_STATUS);
  wire wr_mask   = reg_wr_in && (reg_addr_in == ADDR_IRQ_MASK);

  ////////////////////////////////////////////////////////////////////////////////
  // Rate generation.
  logic div2_en;
  logic per_en;

  csc_rate_gen u_rate_gen (
    .core_clk_in       (core_clk_in),
    .reset_in          (reset_in),
    .boot_speed_in     (boot_speed_fuse_in),
    .double_speed_in   (double_speed_select),
    .div2_en_out       (div2_en),
    .per_en_out        (per_en),
    .mcyc_en_out       (mcyc_en_out),
    .double_active_out (double_active_out)
  );

  assign osc_div2_en_out = div2_en;
  assign cpu_clk_en_out  = per_en;
  assign per_clk_en_out  = per_en;

  // Each peripheral's select bit picks either the fixed half rate or the mode-dependent rate.
  logic [SEL_W-1:0] periph_clk_en;

  generate
    for (genvar i = 0; i < SEL_W; i++)
    begin : g_sel
      assign periph_clk_en[i] = periph_select[i] ? div2_en : per_en;
    end
  endgenerate

  assign timer0_clk_en_out   = periph_clk_en[0];
  assign timer1_clk_en_out   = periph_clk_en[1];
  assign uart_clk_en_out     = periph_clk_en[2];
  assign watchdog_clk_en_out = periph_clk_en[3];
  assign twowire_clk_en_out  = periph_clk_en[4];

  ////////////////////////////////////////////////////////////////////////////////
  // Frequency synthesiser: dividers, controlled oscillator and detector.
  logic        synth_run;
  logic [15:0] nco_inc;
  logic [15:0] nco_acc;
  logic [16:0] nco_sum;
  logic        vco_tick;
  logic [6:0]  ref_cnt;
  logic [9:0]  fb_cnt;
  logic [9:0]  feedback_divide;
  logic        ref_tick;
  logic        fb_tick;
  csc_pfd_t    pfd;

  assign synth_run       = synth_enable_bit && !synth_reset_bit;
  assign nco_sum         = {1'b0, nco_acc} + {1'b0, nco_inc};
  assign vco_tick        = synth_run && nco_sum[16];
  assign feedback_divide = {feedback_divide_upper, feedback_divide_lower};
  assign ref_tick        = synth_run && (ref_cnt == reference_divide_value);
  assign fb_tick         = vco_tick && (fb_cnt == feedback_divide);

  csc_phase_detect u_phase_detect (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .run_in      (synth_run),
    .ref_tick_in (ref_tick),
    .fb_tick_in  (fb_tick),
    .pfd_out     (pfd)
  );

  always_ff @(posedge core_clk_in)
  begin
    if (reset_in || !synth_run)
    begin
      nco_acc <= 16'h0000;
      nco_inc <= NCO_INIT;
      ref_cnt <= 7'h00;
      fb_cnt  <= 10'h000;
    end
    else
    begin
      nco_acc <= nco_sum[15:0];
      if (pfd.up && (nco_inc != 16'hffff))
        nco_inc <= nco_inc + 16'h0001;
      else if (pfd.down && (nco_inc != 16'h0001))
        nco_inc <= nco_inc - 16'h0001;
      ref_cnt <= ref_tick ? 7'h00 : ref_cnt + 7'h01;
      if (vco_tick)
        fb_cnt <= fb_tick ? 10'h000 : fb_cnt + 10'h001;
    end
  end

  assign synth_clk_en_out = vco_tick;
  assign audio_clk_en_out = vco_tick;
  assign usb_clk_en_out   = vco_tick;

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes.
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      double_speed_select    <= boot_speed_fuse_in;
      periph_select          <= SEL_RESET;
      synth_enable_bit       <= SYNTH_CTRL_RESET[SC_ENABLE];
      synth_reset_bit        <= SYNTH_CTRL_RESET[SC_RESET];
      feedback_divide_lower  <= SYNTH_CTRL_RESET[SC_FB_LO+1:SC_FB_LO];
      reference_divide_value <= REF_DIV_RESET;
      feedback_divide_upper  <= FB_DIV_RESET;
      irq_mask               <= '0;
    end
    else
    begin
      if (wr_speed)
      begin
        double_speed_select <= reg_wdata_in[CKS_DOUBLE];
        periph_select       <= {reg_wdata_in[CKS_TWOWIRE], reg_wdata_in[CKS_WATCHDOG],
                                reg_wdata_in[CKS_UART], reg_wdata_in[CKS_TIMER1],
                                reg_wdata_in[CKS_TIMER0]};
      end
      if (wr_ctrl)
      begin
        synth_enable_bit      <= reg_wdata_in[SC_ENABLE];
        synth_reset_bit       <= reg_wdata_in[SC_RESET];
        feedback_divide_lower <= reg_wdata_in[SC_FB_LO+1:SC_FB_LO];
      end
      if (wr_ref)
        reference_divide_value <= reg_wdata_in[6:0];
      if (wr_fb)
        feedback_divide_upper <= reg_wdata_in;
      if (wr_mask)
        irq_mask <= reg_wdata_in[IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Lock events and interrupt; a new event wins over a clear in the same cycle.
  logic [IRQ_W-1:0] irq_event;

  assign irq_event[IRQ_LOCK_GAINED] = pfd.locked && !lock_prev;
  assign irq_event[IRQ_LOCK_LOST]   = !pfd.locked && lock_prev;

  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      irq_status <= '0;
      lock_prev  <= 1'b0;
    end
    else
    begin
      lock_prev  <= pfd.locked;
      irq_status <= (irq_status & ~(wr_status ? reg_wdata_in[IRQ_W-1:0] : '0)) | irq_event;
    end
  end

  assign irq_out = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////////
  // Read path; reserved speed bits and unmapped addresses read zero.
  logic [7:0] rd_speed;
  logic [7:0] rd_ctrl;
  logic [7:0] rd_mux;

  assign rd_speed = {periph_select[4], periph_select[3], 1'b0, periph_select[2],
                     1'b0, periph_select[1], periph_select[0], double_speed_select};
  assign rd_ctrl  = {feedback_divide_lower, 2'b00, synth_reset_bit, 1'b0,
                     synth_enable_bit, pfd.locked};

  assign rd_mux = (reg_addr_in == ADDR_CLOCK_SPEED) ? rd_speed :
                  (reg_addr_in == ADDR_SYNTH_CTRL)  ? rd_ctrl :
                  (reg_addr_in == ADDR_REF_DIV)     ? {1'b0, reference_divide_value} :
                  (reg_addr_in == ADDR_FB_DIV)      ? feedback_divide_upper :
                  (reg_addr_in == ADDR_IRQ_STATUS)  ? {6'h00, irq_status} :
                  (reg_addr_in == ADDR_IRQ_MASK)    ? {6'h00, irq_mask} : 8'h00;

  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      reg_rdata_out <= 8'h00;
    else if (reg_rd_in)
      reg_rdata_out <= rd_mux;
    else
      reg_rdata_out <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  speed_reset_a: assert property (@(posedge core_clk_in)
    $past(reset_in) |-> (rd_speed == {7'h00, $past(boot_speed_fuse_in)}))
    else $error("Speed register reset value wrong.");

  ctrl_reset_a: assert property (@(posedge core_clk_in)
    $past(reset_in) |-> (rd_ctrl == SYNTH_CTRL_RESET) && !synth_clk_en_out)
    else $error("Control register reset value wrong.");

  synth_gate_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    synth_clk_en_out |-> synth_enable_bit && !synth_reset_bit)
    else $error("Synthesiser clock runs while disabled.");

  lock_clear_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !synth_run ##1 !synth_run |-> !rd_ctrl[SC_LOCK])
    else $error("Lock flag set while loop is stopped.");

  route_same_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (audio_clk_en_out == synth_clk_en_out) && (usb_clk_en_out == synth_clk_en_out))
    else $error("Audio or USB clock not from synthesiser.");

  twowire_half_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    periph_select[4] && twowire_clk_en_out ##1 periph_select[4] |-> !twowire_clk_en_out)
    else $error("Two-wire clock faster than half rate.");

  timer_mux_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !periph_select[0] && double_active_out |-> timer0_clk_en_out)
    else $error("Timer 0 clock not following peripheral rate.");

  uart_mux_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    periph_select[2] |-> (uart_clk_en_out == osc_div2_en_out))
    else $error("UART clock not at half oscillator rate.");

  std_rate_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !double_active_out && per_clk_en_out ##1 !double_active_out |-> !per_clk_en_out)
    else $error("Standard mode peripheral clock too fast.");

  ref_div_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    wr_ref ##1 reg_rd_in && (reg_addr_in == ADDR_REF_DIV) |=>
      reg_rdata_out == {1'b0, $past(reg_wdata_in[6:0], 2)})
    else $error("Reference divider readback wrong.");

  irq_level_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    irq_event[IRQ_LOCK_GAINED] && irq_mask[IRQ_LOCK_GAINED] && !wr_mask |=> irq_out)
    else $error("Lock interrupt lost.");

  ////////////////////////////////////////////////////////////////////////////////
  // Bus, status, clock rate and synthesiser checks. A clear that meets a new event must not lose the event.
  rdata_idle_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !$past(reg_rd_in) |-> (reg_rdata_out == 8'h00))
    else $error("Read data not zero between reads.");

  status_set_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (irq_event != '0) |=> ((irq_status & $past(irq_event)) == $past(irq_event)))
    else $error("Lock event not recorded.");

  status_clear_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    wr_status && (irq_event == '0) |=> ((irq_status & $past(reg_wdata_in[IRQ_W-1:0])) == '0))
    else $error("Status bit not cleared by write.");

  double_rate_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    double_active_out |-> cpu_clk_en_out && per_clk_en_out)
    else $error("Double speed clock not at full rate.");

  watchdog_mux_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    periph_select[3] |-> (watchdog_clk_en_out == osc_div2_en_out))
    else $error("Watchdog clock not at half oscillator rate.");

  twowire_per_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !periph_select[4] |-> (twowire_clk_en_out == per_clk_en_out))
    else $error("Two-wire clock not following peripheral rate.");

  synth_hold_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    synth_reset_bit |-> !synth_clk_en_out && !usb_clk_en_out)
    else $error("Synthesiser runs while held in reset.");

  fb_upper_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    wr_fb |=> (feedback_divide == {$past(reg_wdata_in), feedback_divide_lower}))
    else $error("Feedback divider upper bits not written.");

  fb_lower_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
    wr_ctrl |=> (feedback_divide[1:0] == $past(reg_wdata_in[SC_FB_LO+1:SC_FB_LO])))
    else $error("Feedback divider low bits not written.");

endmodule
`default_nettype wire

/* File: test/tb_csc_clock_ctrl.sv */
`default_nettype none
module tb_csc_clock_ctrl
  import csc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end

  ////////////////////////////////////////////////////////////////////////////////
  logic       core_clk_in;
  logic       reset_in;
  logic       boot_speed_fuse_in;
  logic [7:0] reg_addr_in;
  logic [7:0] reg_wdata_in;
  logic       reg_wr_in;
  logic       reg_rd_in;
  logic [7:0] reg_rdata_out;
  logic       div2, cpu, per, mcyc, dbl, tw, wd, ua, t1, t0, syn, aud, usb, irq;
  int         fail_count = 0;
  int         num_checks = 0;
  logic [31:0] seed = 32'had17;
  int         m_speed, m_ctrl, m_ref, m_fb, m_mask;
  logic [7:0] d;
  logic [7:0] probe_addr [5] = '{ADDR_CLOCK_SPEED, ADDR_SYNTH_CTRL, ADDR_REF_DIV,
                                 ADDR_FB_DIV, 8'h55};

  csc_clock_ctrl DUT (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .boot_speed_fuse_in(boot_speed_fuse_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .osc_div2_en_out(div2), .cpu_clk_en_out(cpu),
    .per_clk_en_out(per), .mcyc_en_out(mcyc), .double_active_out(dbl),
    .twowire_clk_en_out(tw), .watchdog_clk_en_out(wd), .uart_clk_en_out(ua),
    .timer1_clk_en_out(t1), .timer0_clk_en_out(t0), .synth_clk_en_out(syn),
    .audio_clk_en_out(aud), .usb_clk_en_out(usb), .irq_out(irq));

  initial
  begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    t = t ^ (t << 5);
    return t;
  endfunction

  // The model keeps every register software can see except the interrupt status; lock is tracked apart.
  task automatic do_reset(input logic fuse);
    boot_speed_fuse_in <= fuse;
    reset_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    reset_in <= 1'b0;
    m_speed = {7'h00, fuse};
    m_ctrl = 8'h08;
    m_ref = 0;
    m_fb = 0;
    m_mask = 0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
    case (a)
      ADDR_CLOCK_SPEED: m_speed = v & 8'hd7;
      ADDR_SYNTH_CTRL:  m_ctrl = v & 8'hca;
      ADDR_REF_DIV:     m_ref = v & 8'h7f;
      ADDR_FB_DIV:      m_fb = v;
      ADDR_IRQ_MASK:    m_mask = v & 8'h03;
      default: ;
    endcase
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1 v = reg_rdata_out;
  endtask

  // A write and a read on consecutive strobes; the read must already see the new value.
  task automatic wrrd(input logic [7:0] a, input logic [7:0] v, input logic [7:0] e);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1 `CHK("back to back", e, reg_rdata_out)
  endtask

  task automatic rdchk(input logic [7:0] a);
    logic [7:0] e;
    e = (a == ADDR_CLOCK_SPEED) ? m_speed[7:0] : (a == ADDR_SYNTH_CTRL) ? m_ctrl[7:0] :
        (a == ADDR_REF_DIV) ? m_ref[7:0] : (a == ADDR_FB_DIV) ? m_fb[7:0] :
        (a == ADDR_IRQ_MASK) ? m_mask[7:0] : 8'h00;
    rd(a, d);
    if (a == ADDR_SYNTH_CTRL)
      d[0] = 1'b0;
    `CHK("register read", e, d)
  endtask

  // One machine cycle measured edge to edge, with every peripheral select checked.
  task automatic check_rate(input int len);
    int n, nc, nd;
    logic [7:0] s;
    n = 0;
    nc = 0;
    nd = 0;
    s = m_speed[7:0];
    @(posedge core_clk_in);
    #1;
    while (mcyc !== 1'b1 && n < 30)
    begin
      @(posedge core_clk_in);
      #1 n++;
    end
    n = 0;
    do
    begin
      @(posedge core_clk_in);
      #1 n++;
      nc += (cpu === 1'b1);
      nd += (div2 === 1'b1);
      `CHK("cpu vs per", cpu, per)
      `CHK("twowire", s[7] ? div2 : per, tw)
      `CHK("watchdog", s[6] ? div2 : per, wd)
      `CHK("uart", s[4] ? div2 : per, ua)
      `CHK("timer1", s[2] ? div2 : per, t1)
      `CHK("timer0", s[1] ? div2 : per, t0)
    end
    while (mcyc !== 1'b1 && n < 30);
    `CHK("machine cycle", len, n)
    `CHK("cpu pulses", 6, nc)
    `CHK("div2 pulses", len / 2, nd)
  endtask

  // Speed changes land at a machine-cycle end; the new rate must be whole.
  task automatic set_speed(input logic [7:0] v);
    int n;
    n = 0;
    wr(ADDR_CLOCK_SPEED, v & 8'hd7);
    while (dbl !== v[0] && n < 14)
    begin
      @(posedge core_clk_in);
      #1 n++;
    end
    `CHK("speed adopted", v[0], dbl)
    check_rate(v[0] ? 6 : 12);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #300000;
    fail_count++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int n, ns;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reset_in = 1'b1;
    boot_speed_fuse_in = 1'b0;
    do_reset(1'b0);
    foreach (probe_addr[i])
      rdchk(probe_addr[i]);
    @(posedge core_clk_in);
    #1 `CHK("rdata idle", 8'h00, reg_rdata_out)
    `CHK("boot standard", 1'b0, dbl)
    check_rate(12);
    $display("test reset and standard rate done");
    for (int k = 0; k < 6; k++)
    begin
      seed = xs(seed);
      set_speed(seed[7:0]);
      rdchk(ADDR_CLOCK_SPEED);
    end
    $display("test random speed selects done");
    @(posedge core_clk_in);
    do_reset(1'b1);
    rdchk(ADDR_CLOCK_SPEED);
    `CHK("boot double", 1'b1, dbl)
    check_rate(6);
    $display("test fuse boot done");
    wrrd(ADDR_REF_DIV, 8'hff, 8'h7f);
    m_ref = 8'h7f;
    rdchk(ADDR_REF_DIV);
    seed = xs(seed);
    wr(ADDR_FB_DIV, seed[7:0]);
    rdchk(ADDR_FB_DIV);
    wr(ADDR_REF_DIV, 8'h03);
    wr(ADDR_FB_DIV, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h01);
    rdchk(ADDR_IRQ_MASK);
    wr(ADDR_SYNTH_CTRL, 8'h4a);
    rdchk(ADDR_SYNTH_CTRL);
    ns = 0;
    repeat (40)
    begin
      @(posedge core_clk_in);
      #1 ns += (syn === 1'b1);
    end
    `CHK("held in reset", 0, ns)
    wr(ADDR_SYNTH_CTRL, 8'h02);
    ns = 0;
    repeat (200)
    begin
      @(posedge core_clk_in);
      #1 ns += (syn === 1'b1);
      `CHK("audio clock", syn, aud)
      `CHK("usb clock", syn, usb)
    end
    `CHK("synth running", 1'b1, ns > 0)
    n = 0;
    d = 8'h00;
    while (d[SC_LOCK] !== 1'b1 && n < 2000)
    begin
      rd(ADDR_SYNTH_CTRL, d);
      n++;
    end
    `CHK("lock gained", 1'b1, d[SC_LOCK])
    `CHK("irq on lock", 1'b1, irq)
    wr(ADDR_IRQ_STATUS, 8'h01);
    #1 `CHK("irq cleared", 1'b0, irq)
    $display("test synth lock done");
    wr(ADDR_SYNTH_CTRL, 8'h00);
    ns = 0;
    repeat (100)
    begin
      @(posedge core_clk_in);
      #1 ns += (syn === 1'b1);
    end
    `CHK("synth stopped", 0, ns)
    rd(ADDR_SYNTH_CTRL, d);
    `CHK("lock dropped", 1'b0, d[SC_LOCK])
    rd(ADDR_IRQ_STATUS, d);
    `CHK("lost event", 1'b1, d[IRQ_LOCK_LOST])
    `CHK("irq masked", 1'b0, irq)
    wr(ADDR_IRQ_MASK, 8'h03);
    #1 `CHK("irq unmasked", 1'b1, irq)
    wr(ADDR_IRQ_STATUS, 8'h02);
    #1 `CHK("irq idle", 1'b0, irq)
    $display("test synth stop and interrupt done");
    summarize();
  end

`undef CHK
endmodule
`default_nettype wire
